/* File: operand_resolver_defines.svh */
`ifndef OPERAND_RESOLVER_DEFINES_SVH
`define OPERAND_RESOLVER_DEFINES_SVH

// ----------------------------------------
// data memory banks and windows
// ----------------------------------------
`define BANK0 4'h0
`define BANK1 4'h1
`define BANK15 4'hF
`define BANK_RESET 4'h0
`define FLAG_RESET 1'b0
`define MEM_LOW_TOP 8'h7F
`define FMEM_LO_PAGE 4'hB
`define FMEM_HI_PAGE 4'hF
`define PMEM_PAGE_BITS 2'h3

// ----------------------------------------
// program memory targets
// ----------------------------------------
`define REL_BACK_MIN 6'sh31
`define REL_BACK_MAX 6'sh3F
`define REL_FWD_MIN 6'sh02
`define REL_FWD_MAX 6'sh10
`define ROM_TOP 13'h1FFF
`define TABLE_LO 7'h20

// ----------------------------------------
// skip cost
// ----------------------------------------
`define SKIP_NONE 2'h0
`define SKIP_SHORT 2'h1
`define SKIP_LONG 2'h2
`define LEN_THREE 2'h3

// ----------------------------------------
// reset wait, in main clock periods
// ----------------------------------------
`define WAIT_LONG_PERIODS 131072
`define WAIT_SHORT_PERIODS 32768
`define CLK_PER_MAIN_PERIOD 1
`define WAIT_CNT_W 18
`define SYNC_STAGES 2

`endif

/* File: operand_resolver_pkg.sv */
package operand_resolver_pkg;

  // ----------------------------------------
  // operand kinds
  // ----------------------------------------
  typedef enum logic [3:0] {
    MODE_HL_INDIRECT = 4'h0,
    MODE_PAIR_INDIRECT = 4'h1,
    MODE_DIRECT_MEM = 4'h2,
    MODE_FMEM = 4'h3,
    MODE_PMEM = 4'h4,
    MODE_REL_BRANCH = 4'h5,
    MODE_IN_BLOCK = 4'h6,
    MODE_FAST_CALL = 4'h7,
    MODE_TABLE_VEC = 4'h8,
    MODE_ABSOLUTE = 4'h9
  } mode_type;

  typedef enum logic [1:0] {
    WAIT_IDLE = 2'h0,
    WAIT_COUNT = 2'h1,
    WAIT_RUN = 2'h3
  } wait_state_type;

  typedef struct packed {
    logic valid;
    mode_type mode;
    logic wide;
    logic [12:0] operand;
    logic [7:0] pointer;
    logic [1:0] bit_pos;
    logic [12:0] pc;
  } request_type;

  typedef struct packed {
    logic valid;
    logic err;
    logic is_prog;
    logic [11:0] data_addr;
    logic [12:0] prog_addr;
    logic [3:0] bit_sel;
  } result_type;

  typedef struct packed {
    logic wr;
    logic enable;
    logic [3:0] select;
  } bank_write_type;

endpackage

/* File: reset_wait_timer.sv */
`timescale 1ns/1ns
`include "operand_resolver_defines.svh"

module reset_wait_timer #(
  parameter int LONG_CYCLES = `WAIT_LONG_PERIODS * `CLK_PER_MAIN_PERIOD,
  parameter int SHORT_CYCLES = `WAIT_SHORT_PERIODS * `CLK_PER_MAIN_PERIOD
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // factory wait option pin
  input wire logic long_wait_pin,
  // status
  output logic exec_ready
);
  import operand_resolver_pkg::*;

  logic opt_meta_q;
  logic opt_sync_q;
  logic long_sel_q;
  logic [`WAIT_CNT_W-1:0] count_q;
  logic [`WAIT_CNT_W-1:0] limit;
  wait_state_type state_q;

  // ----------------------------------------
  // option pin synchroniser
  // ----------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      opt_meta_q <= 1'b0;
      opt_sync_q <= 1'b0;
    end else begin
      opt_meta_q <= long_wait_pin;
      opt_sync_q <= opt_meta_q;
    end
  end

  assign limit = long_sel_q ? `WAIT_CNT_W'(LONG_CYCLES) : `WAIT_CNT_W'(SHORT_CYCLES);

  // ----------------------------------------
  // wait sequence
  // ----------------------------------------
  // the option is caught once, after release, so a glitch later cannot stretch the wait
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_q <= WAIT_IDLE;
      long_sel_q <= 1'b0;
      count_q <= '0;
      exec_ready <= 1'b0;
    end else begin
      case (state_q)
        WAIT_IDLE: begin
          // the synchroniser still holds its reset value for two edges after release
          if (count_q == `WAIT_CNT_W'(`SYNC_STAGES)) begin
            long_sel_q <= opt_sync_q;
            count_q <= '0;
            state_q <= WAIT_COUNT;
          end else begin
            count_q <= count_q + `WAIT_CNT_W'(1);
          end
        end
        WAIT_COUNT: begin
          if (count_q == limit - `WAIT_CNT_W'(1)) begin
            exec_ready <= 1'b1;
            state_q <= WAIT_RUN;
          end else begin
            count_q <= count_q + `WAIT_CNT_W'(1);
          end
        end
        WAIT_RUN: exec_ready <= 1'b1;
        default: state_q <= WAIT_IDLE;
      endcase
    end
  end

  property p_wait_length;
    @(posedge clock) disable iff (!rstn)
    $rose(exec_ready) |-> $past(count_q) == limit - `WAIT_CNT_W'(1);
  endproperty
  a_wait_length: assert property (p_wait_length) else $error("wait ended early");

endmodule

/* File: operand_address_resolver.sv */
`timescale 1ns/1ns
`include "operand_resolver_defines.svh"

// What this block does
// - pointer indirect bank is enable AND select
// - DE or DL pointers always bank zero
// - flag clear: low half bank0, high bank15
// - short bit operands fixed in bank 15
// - peripheral bit operands bank15 FC0 to FFF
// - relative branch: minus 15..1, plus 2..16
// - in-block target: 12 bits plus PC bit12
// - fast call reaches only 0000 to 07FF
// - table vector even, 0020 to 007F
// - absolute targets stay within program memory
// - two-bit field selects one nibble bit
// - wait 2^17 or 2^15 periods after reset
// - skip costs one cycle, two for long
module operand_address_resolver
  import operand_resolver_pkg::*;
#(
  parameter int WAIT_LONG_CYCLES = `WAIT_LONG_PERIODS * `CLK_PER_MAIN_PERIOD,
  parameter int WAIT_SHORT_CYCLES = `WAIT_SHORT_PERIODS * `CLK_PER_MAIN_PERIOD
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // factory wait option pin
  input wire logic long_wait_pin,
  // bank state writes from the cpu
  input wire operand_resolver_pkg::bank_write_type bank_wr,
  // decoded operand
  input wire operand_resolver_pkg::request_type req,
  // skip report
  input wire logic skip_taken,
  input wire logic [1:0] skipped_len,
  // resolved address, skip cost, ready and bank state
  output operand_resolver_pkg::result_type result_q,
  output logic [1:0] skip_cycles_q,
  output logic exec_ready_q,
  output logic bank_enable_flag,
  output logic [3:0] bank_select_reg
);
  import operand_resolver_pkg::*;

  logic timer_ready;
  logic accept;
  logic signed [5:0] disp;
  logic [3:0] accessed_bank;
  result_type result_d;

  // ----------------------------------------
  // reset wait
  // ----------------------------------------
  reset_wait_timer #(
    .LONG_CYCLES(WAIT_LONG_CYCLES),
    .SHORT_CYCLES(WAIT_SHORT_CYCLES)
  ) u_wait (
    .clock(clock),
    .rstn(rstn),
    .long_wait_pin(long_wait_pin),
    .exec_ready(timer_ready)
  );

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      exec_ready_q <= 1'b0;
    end else begin
      exec_ready_q <= timer_ready;
    end
  end

  // requests before the wait ends are dropped, the cpu is not running yet
  assign accept = req.valid && exec_ready_q;

  // ----------------------------------------
  // bank state
  // ----------------------------------------
  // a select value outside 0, 1, 15 is ignored and the old bank kept
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bank_enable_flag <= `FLAG_RESET;
      bank_select_reg <= `BANK_RESET;
    end else if (bank_wr.wr) begin
      bank_enable_flag <= bank_wr.enable;
      if (bank_wr.select == `BANK0 || bank_wr.select == `BANK1 ||
          bank_wr.select == `BANK15) begin
        bank_select_reg <= bank_wr.select;
      end
    end
  end

  assign accessed_bank = {4{bank_enable_flag}} & bank_select_reg;
  assign disp = $signed(req.operand[5:0]);

  // ----------------------------------------
  // address resolution
  // ----------------------------------------
  always_comb begin
    result_d = '0;
    result_d.valid = accept;
    result_d.bit_sel = 4'(4'h1 << req.bit_pos);
    case (req.mode)
      MODE_HL_INDIRECT: begin
        result_d.data_addr = {accessed_bank, req.pointer};
      end
      MODE_PAIR_INDIRECT: begin
        result_d.data_addr = {`BANK0, req.pointer};
      end
      MODE_DIRECT_MEM: begin
        if (bank_enable_flag) begin
          result_d.data_addr = {bank_select_reg, req.operand[7:0]};
        end else if (req.operand[7:0] <= `MEM_LOW_TOP) begin
          result_d.data_addr = {`BANK0, req.operand[7:0]};
        end else begin
          result_d.data_addr = {`BANK15, req.operand[7:0]};
        end
        // a wide transfer always pairs an even nibble with the next one
        if (req.wide) begin
          result_d.data_addr[0] = 1'b0;
        end
      end
      MODE_FMEM: begin
        result_d.data_addr = {`BANK15, req.operand[7:0]};
        result_d.err = req.operand[7:4] != `FMEM_LO_PAGE &&
                       req.operand[7:4] != `FMEM_HI_PAGE;
      end
      MODE_PMEM: begin
        result_d.data_addr = {`BANK15, `PMEM_PAGE_BITS, req.pointer[5:0]};
      end
      MODE_REL_BRANCH: begin
        result_d.is_prog = 1'b1;
        result_d.prog_addr = req.pc + {{7{disp[5]}}, disp};
        result_d.err = !((disp >= `REL_BACK_MIN && disp <= `REL_BACK_MAX) ||
                         (disp >= `REL_FWD_MIN && disp <= `REL_FWD_MAX));
      end
      MODE_IN_BLOCK: begin
        result_d.is_prog = 1'b1;
        result_d.prog_addr = {req.pc[12], req.operand[11:0]};
      end
      MODE_FAST_CALL: begin
        result_d.is_prog = 1'b1;
        result_d.prog_addr = {2'h0, req.operand[10:0]};
      end
      MODE_TABLE_VEC: begin
        result_d.is_prog = 1'b1;
        result_d.prog_addr = {6'h00, req.operand[6:1], 1'b0};
        result_d.err = req.operand[0] || req.operand[6:0] < `TABLE_LO ||
                       req.operand[12:7] != 6'h00;
      end
      MODE_ABSOLUTE: begin
        result_d.is_prog = 1'b1;
        result_d.prog_addr = req.operand;
        result_d.err = req.operand > `ROM_TOP;
      end
      default: begin
        result_d.err = 1'b1;
      end
    endcase
    if (!accept) begin
      result_d = '0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      result_q <= '0;
    end else begin
      result_q <= result_d;
    end
  end

  // ----------------------------------------
  // skip cost
  // ----------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      skip_cycles_q <= `SKIP_NONE;
    end else if (!skip_taken) begin
      skip_cycles_q <= `SKIP_NONE;
    end else if (skipped_len == `LEN_THREE) begin
      skip_cycles_q <= `SKIP_LONG;
    end else begin
      skip_cycles_q <= `SKIP_SHORT;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence s_req(mode_type m);
    accept && req.mode == m;
  endsequence

  property p_hl_bank;
    s_req(MODE_HL_INDIRECT) |=>
      result_q.data_addr[11:8] == ($past(bank_enable_flag) ? $past(bank_select_reg) : 4'h0);
  endproperty
  a_hl_bank: assert property (p_hl_bank) else $error("indirect bank wrong");

  property p_pair_bank;
    s_req(MODE_PAIR_INDIRECT) |=> result_q.valid && result_q.data_addr[11:8] == `BANK0;
  endproperty
  a_pair_bank: assert property (p_pair_bank) else $error("pair bank not zero");

  property p_direct_fixed;
    s_req(MODE_DIRECT_MEM) ##0 !bank_enable_flag |=>
      result_q.data_addr[11:8] == (result_q.data_addr[7] ? `BANK15 : `BANK0);
  endproperty
  a_direct_fixed: assert property (p_direct_fixed) else $error("fixed window wrong");

  property p_direct_banked;
    s_req(MODE_DIRECT_MEM) ##0 bank_enable_flag |=>
      result_q.data_addr[11:8] == $past(bank_select_reg);
  endproperty
  a_direct_banked: assert property (p_direct_banked) else $error("banked direct wrong");

  property p_fixed_bit_banks;
    (s_req(MODE_FMEM) or s_req(MODE_PMEM)) |=> result_q.data_addr[11:8] == `BANK15;
  endproperty
  a_fixed_bit_banks: assert property (p_fixed_bit_banks) else $error("bit bank not 15");

  property p_pmem_window;
    s_req(MODE_PMEM) |=> result_q.data_addr[7:6] == `PMEM_PAGE_BITS && !result_q.err &&
      result_q.data_addr[5:0] == $past(req.pointer[5:0]);
  endproperty
  a_pmem_window: assert property (p_pmem_window) else $error("pmem outside window");

  property p_rel_target;
    s_req(MODE_REL_BRANCH) |=> result_q.err ||
      (result_q.prog_addr - $past(req.pc) inside {[13'h1FF1:13'h1FFF], [13'h0002:13'h0010]});
  endproperty
  a_rel_target: assert property (p_rel_target) else $error("relative target out");

  property p_block_target;
    s_req(MODE_IN_BLOCK) |=> result_q.prog_addr == {$past(req.pc[12]), $past(req.operand[11:0])};
  endproperty
  a_block_target: assert property (p_block_target) else $error("in-block target wrong");

  property p_fast_call;
    s_req(MODE_FAST_CALL) |=> result_q.prog_addr == {2'h0, $past(req.operand[10:0])};
  endproperty
  a_fast_call: assert property (p_fast_call) else $error("fast call too high");

  property p_table_vec;
    s_req(MODE_TABLE_VEC) |=> result_q.err ||
      (!result_q.prog_addr[0] && result_q.prog_addr inside {[13'h0020:13'h007F]});
  endproperty
  a_table_vec: assert property (p_table_vec) else $error("table vector out");

  property p_abs_target;
    s_req(MODE_ABSOLUTE) |=> !result_q.err && result_q.prog_addr == $past(req.operand);
  endproperty
  a_abs_target: assert property (p_abs_target) else $error("absolute target out");

  property p_bit_onehot;
    accept |=> $onehot(result_q.bit_sel) && result_q.bit_sel[$past(req.bit_pos)];
  endproperty
  a_bit_onehot: assert property (p_bit_onehot) else $error("bit select wrong");

  sequence s_skip_long;
    skip_taken && skipped_len == `LEN_THREE;
  endsequence

  property p_skip_cost;
    skip_taken |=> skip_cycles_q == ($past(skipped_len) == `LEN_THREE ? `SKIP_LONG : `SKIP_SHORT);
  endproperty
  a_skip_cost: assert property (p_skip_cost) else $error("skip cost wrong");

  property p_skip_long;
    s_skip_long ##1 !skip_taken |=> skip_cycles_q == `SKIP_NONE;
  endproperty
  a_skip_long: assert property (p_skip_long) else $error("skip cost stuck");

  property p_wait_gate;
    !exec_ready_q |=> !result_q.valid;
  endproperty
  a_wait_gate: assert property (p_wait_gate) else $error("request before wait end");

  property p_bank_hold;
    !bank_wr.wr |=> $stable(bank_enable_flag) && $stable(bank_select_reg);
  endproperty
  a_bank_hold: assert property (p_bank_hold) else $error("bank state moved");

endmodule

/* File: cpu_side_model.sv */
`timescale 1ns/1ns

module cpu_side_model (
  // clock
  input wire logic clock,
  // toward the resolver
  output operand_resolver_pkg::request_type req,
  output operand_resolver_pkg::bank_write_type bank_wr,
  output logic skip_taken,
  output logic [1:0] skipped_len
);
  import operand_resolver_pkg::*;

  int gap_cycles = 0;

  initial begin
    req = '0;
    bank_wr = '0;
    skip_taken = 1'b0;
    skipped_len = 2'h0;
  end

  // ----------------------------------------
  // issue tasks
  // ----------------------------------------
  // released fields turn to their inverse so a stale value never looks fresh
  task automatic send(input request_type r);
    request_type idle;
    repeat (gap_cycles) @(posedge clock);
    if (r.wide) begin
      r.operand[0] = 1'b0;
    end
    idle = request_type'(~r);
    idle.valid = 1'b0;
    @(posedge clock);
    req <= r;
    @(posedge clock);
    req <= idle;
  endtask

  task automatic bank_write(input logic en, input logic [3:0] sel);
    @(posedge clock);
    bank_wr <= '{1'b1, en, sel};
    @(posedge clock);
    bank_wr <= '{1'b0, ~en, ~sel};
  endtask

  task automatic skip(input logic take, input logic [1:0] len);
    @(posedge clock);
    skip_taken <= take;
    skipped_len <= len;
    @(posedge clock);
    skip_taken <= 1'b0;
    skipped_len <= ~len;
  endtask
endmodule

/* File: tb_operand_address_resolver.sv */
`timescale 1ns/1ns

module tb_operand_address_resolver;
  import operand_resolver_pkg::*;

  // shortened reset waits keep the run brief
  localparam int LONG_W = 20;
  localparam int SHORT_W = 8;
  localparam logic [15:0] ERR = 16'hC000;

  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic long_wait_pin = 1'b1;
  request_type req;
  bank_write_type bank_wr;
  logic skip_taken;
  logic [1:0] skipped_len;
  result_type result_q;
  logic [1:0] skip_cycles_q;
  logic exec_ready_q;
  logic bank_enable_flag;
  logic [3:0] bank_select_reg;
  int n_mismatch = 0;
  int samples_checked = 0;

  initial begin
    forever #4 clock = ~clock;
  end

  operand_address_resolver #(
    .WAIT_LONG_CYCLES(LONG_W),
    .WAIT_SHORT_CYCLES(SHORT_W)
  ) dut_u (
    .clock(clock),
    .rstn(rstn),
    .long_wait_pin(long_wait_pin),
    .bank_wr(bank_wr),
    .req(req),
    .skip_taken(skip_taken),
    .skipped_len(skipped_len),
    .result_q(result_q),
    .skip_cycles_q(skip_cycles_q),
    .exec_ready_q(exec_ready_q),
    .bank_enable_flag(bank_enable_flag),
    .bank_select_reg(bank_select_reg)
  );

  cpu_side_model partner_u (
    .clock(clock),
    .req(req),
    .bank_wr(bank_wr),
    .skip_taken(skip_taken),
    .skipped_len(skipped_len)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  function automatic logic [15:0] pa(input logic [12:0] a);
    return {3'b101, a};
  endfunction

  function automatic logic [15:0] da(input logic [11:0] a);
    return {4'b1000, a};
  endfunction

  // address is masked on a refusal, only valid and err matter then
  task automatic expect_addr(input string name, input mode_type m, input logic [12:0] op,
    input logic [7:0] ptr, input logic [12:0] pc, input logic [15:0] exp);
    logic [15:0] seen;
    partner_u.send('{1'b1, m, 1'b0, op, ptr, 2'h0, pc});
    #1;
    seen = {result_q.valid, result_q.err, result_q.is_prog,
      result_q.is_prog ? result_q.prog_addr : {1'b0, result_q.data_addr}};
    if (result_q.err === 1'b1) begin
      seen[13:0] = 14'h0;
    end
    check(name, seen, exp);
  endtask

  task automatic bank_set(input logic en, input logic [3:0] sel, input logic [3:0] exp_sel);
    partner_u.bank_write(en, sel);
    #1;
    check("flag", {15'h0, bank_enable_flag}, {15'h0, en});
    check("select", {12'h0, bank_select_reg}, {12'h0, exp_sel});
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic do_reset(input logic pin, input int w);
    int n;
    @(posedge clock);
    rstn <= 1'b0;
    long_wait_pin <= pin;
    repeat (10) @(posedge clock);
    #1;
    check("ready in reset", {15'h0, exec_ready_q}, 16'h0);
    @(posedge clock);
    rstn <= 1'b1;
    partner_u.send('{1'b1, MODE_ABSOLUTE, 1'b0, 13'h0123, 8'h0, 2'h0, 13'h0});
    #1;
    n = 2;
    check("early request", {15'h0, result_q.valid}, 16'h0);
    check("flag reset", {15'h0, bank_enable_flag}, 16'h0);
    check("select reset", {12'h0, bank_select_reg}, 16'h0);
    while (exec_ready_q !== 1'b1 && n < 200) begin
      @(posedge clock);
      #1;
      n++;
    end
    check("wait length", {15'h0, n >= w && n <= w + 4}, 16'h1);
  endtask

  task automatic scen_data();
    bank_set(1'b0, 4'h1, 4'h1);
    expect_addr("hl clear", MODE_HL_INDIRECT, 13'h0, 8'h34, 13'h0, da(12'h034));
    bank_set(1'b1, 4'h1, 4'h1);
    expect_addr("hl b1", MODE_HL_INDIRECT, 13'h0, 8'h34, 13'h0, da(12'h134));
    expect_addr("pair b1", MODE_PAIR_INDIRECT, 13'h0, 8'h5A, 13'h0, da(12'h05A));
    bank_set(1'b1, 4'h5, 4'h1);
    bank_set(1'b1, 4'hF, 4'hF);
    expect_addr("hl b15", MODE_HL_INDIRECT, 13'h0, 8'hA7, 13'h0, da(12'hFA7));
    expect_addr("pair b15", MODE_PAIR_INDIRECT, 13'h0, 8'hA7, 13'h0, da(12'h0A7));
    expect_addr("mem set", MODE_DIRECT_MEM, 13'h0012, 8'h0, 13'h0, da(12'hF12));
    bank_set(1'b0, 4'hF, 4'hF);
    expect_addr("mem lo", MODE_DIRECT_MEM, 13'h007F, 8'h0, 13'h0, da(12'h07F));
    expect_addr("mem hi", MODE_DIRECT_MEM, 13'h0080, 8'h0, 13'h0, da(12'hF80));
    bank_set(1'b1, 4'h1, 4'h1);
    expect_addr("mem b1", MODE_DIRECT_MEM, 13'h0080, 8'h0, 13'h0, da(12'h180));
    partner_u.send('{1'b1, MODE_DIRECT_MEM, 1'b1, 13'h0023, 8'h0, 2'h0, 13'h0});
    #1;
    check("mem wide", {4'h0, result_q.data_addr}, 16'h0122);
    expect_addr("fmem b", MODE_FMEM, 13'h00B5, 8'h0, 13'h0, da(12'hFB5));
    expect_addr("fmem f", MODE_FMEM, 13'h00F3, 8'h0, 13'h0, da(12'hFF3));
    expect_addr("fmem bad", MODE_FMEM, 13'h00C0, 8'h0, 13'h0, ERR);
    expect_addr("pmem lo", MODE_PMEM, 13'h0, 8'hC0, 13'h0, da(12'hFC0));
    expect_addr("pmem hi", MODE_PMEM, 13'h0, 8'h3F, 13'h0, da(12'hFFF));
  endtask

  task automatic scen_program();
    logic [5:0] disp [8] = '{6'h31, 6'h3F, 6'h02, 6'h10, 6'h00, 6'h01, 6'h30, 6'h11};
    logic [15:0] exp;
    partner_u.gap_cycles = 2;
    for (int i = 0; i < 8; i++) begin
      exp = i < 4 ? pa(13'h0100 + {{7{disp[i][5]}}, disp[i]}) : ERR;
      expect_addr("rel", MODE_REL_BRANCH, {7'h0, disp[i]}, 8'h0, 13'h0100, exp);
    end
    partner_u.gap_cycles = 0;
    expect_addr("blk up", MODE_IN_BLOCK, 13'h0234, 8'h0, 13'h1F00, pa(13'h1234));
    expect_addr("blk lo", MODE_IN_BLOCK, 13'h1234, 8'h0, 13'h0F00, pa(13'h0234));
    expect_addr("fcall", MODE_FAST_CALL, 13'h07FF, 8'h0, 13'h1F00, pa(13'h07FF));
    expect_addr("tbl lo", MODE_TABLE_VEC, 13'h0020, 8'h0, 13'h0, pa(13'h0020));
    expect_addr("tbl hi", MODE_TABLE_VEC, 13'h007E, 8'h0, 13'h0, pa(13'h007E));
    expect_addr("tbl odd", MODE_TABLE_VEC, 13'h0021, 8'h0, 13'h0, ERR);
    expect_addr("tbl low", MODE_TABLE_VEC, 13'h001E, 8'h0, 13'h0, ERR);
    expect_addr("tbl up", MODE_TABLE_VEC, 13'h0080, 8'h0, 13'h0, ERR);
    expect_addr("abs top", MODE_ABSOLUTE, 13'h1FFF, 8'h0, 13'h0, pa(13'h1FFF));
  endtask

  task automatic scen_bits_skip();
    logic [1:0] cost [4] = '{2'h0, 2'h1, 2'h1, 2'h2};
    for (int i = 0; i < 4; i++) begin
      partner_u.send('{1'b1, MODE_FMEM, 1'b0, 13'h00B0, 8'h0, i[1:0], 13'h0});
      #1;
      check("bit sel", {12'h0, result_q.bit_sel}, 16'h1 << i);
    end
    for (int i = 1; i < 4; i++) begin
      partner_u.skip(1'b1, i[1:0]);
      #1;
      check("skip", {14'h0, skip_cycles_q}, {14'h0, cost[i]});
    end
    partner_u.skip(1'b0, 2'h3);
    #1;
    check("no skip", {14'h0, skip_cycles_q}, 16'h0);
  endtask

  initial begin
    do_reset(1'b1, LONG_W);
    scen_data();
    scen_program();
    scen_bits_skip();
    do_reset(1'b0, SHORT_W);
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    summarize();
  end
endmodule
